// file: hdl/adcd_top.v
// diagnostic sequencer, evaluator and AXI4-Lite register file for the acquisition engine
// assumes a converter that answers each conv_start with one conv_done pulse carrying conv_data
// How it works
// - code 1001 grounds converter inputs, thermistor reference, bipolar acquisition.
// - with calibration on, thermistor-offset result gets calibration coefficient added.
// - code 1100 shorts amplifier inputs, forces bipolar, skips chopping phase.
// - code 1010 drives negative rail, bipolar; healthy result all zeros.
// - code 1011 drives positive rail, bipolar; healthy result 3FFCh.
// - end-of-scan enable appends zero-scale and full-scale checks to each scan.
// - quarter-scale selection loads threshold DAC with 0x100 and measures it.
// - three-quarter selection loads threshold DAC with 2FFh and measures it.
// - scan config 100 short, 101 open, 110 odd wire, 111 even wire.
// - switch modes reconfigure acquisition and alternate mux; host still starts scan.
// - switch-mode scan start clears all 14 per-channel alert bits.
// - alerts written at scan completion, held until next switch-mode scan.
// - short mode flags channel measuring below short threshold.
// - open and wire modes flag below low or above high threshold.
// - summary alert is OR of 14 channel alerts at scan end.
// - equal top cells mask alerts at and above top cell; differing masks none.
// - summary clears when later scan resolves alerts, or software writes zero.
// - switch modes leave overvoltage, undervoltage, mismatch alerts untouched.
// - short mode turns all balancing switches off during the scan.
// - open mode measures only enabled switches at unipolar positions.
`timescale 1ns/1ns
`default_nettype none
`include "adcd_regs.vh"

module adcd_top #(
  parameter NCH = 14
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire conv_start,
  output wire [2:0] conv_src,
  output wire [3:0] conv_channel,
  output wire conv_bipolar,
  output wire conv_no_chop,
  output wire conv_therm_ref,
  output wire [9:0] dac_code,
  output wire alternate_mux_path,
  output wire [NCH-1:0] balance_switch_drive,
  output wire cell_alert_update,
  input wire conv_done,
  input wire [13:0] conv_data
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_NEXT = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [4:0] IT_A = NCH;
  localparam [4:0] IT_B = NCH + 1;
  localparam [4:0] IT_ZS = NCH + 2;
  localparam [4:0] IT_FS = NCH + 3;
  localparam [4:0] IT_END = NCH + 4;

  // ==========================================================
  // register state
  reg [3:0] sel_a_q, sel_b_q, top_a_q, top_b_q;
  reg cal_en_q, eos_en_q;
  reg [2:0] scan_cfg_q;
  reg [13:0] short_thr_q, low_thr_q, high_thr_q, cal_coef_q;
  reg [NCH-1:0] bal_en_q, pol_q, alert_q, pend_q;
  reg sum_q, done_flag_q;
  reg [15:0] res_a_q, res_b_q;
  reg [13:0] zs_q, fs_q;
  reg start_q, busy_q;
  reg [1:0] st_q;
  reg [4:0] idx_q;
  reg [2:0] mode_q;
  reg cstart_q, cbip_q, cnochop_q, ctherm_q, cupd_q, alternate_mux_path_q;
  reg [2:0] csrc_q;
  reg [3:0] cch_q;
  reg [9:0] cdac_q;
  reg [NCH-1:0] bal_drv_q;

  // ==========================================================
  // AXI4-Lite write channel
  reg aw_q, w_q, bvalid_q;
  reg [1:0] bresp_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_d;
  reg rd_ok;
  wire do_wr;
  wire wr_hit;
  wire sum_clr;
  wire start_req;

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_wr = aw_q && w_q;
  assign wr_hit = (awaddr_q == `ADCD_OFF_DIAG_CFG) || (awaddr_q == `ADCD_OFF_SCAN_CTRL) ||
                  (awaddr_q == `ADCD_OFF_SHORT_THR) || (awaddr_q == `ADCD_OFF_LOW_THR) ||
                  (awaddr_q == `ADCD_OFF_HIGH_THR) || (awaddr_q == `ADCD_OFF_ALERT) ||
                  (awaddr_q == `ADCD_OFF_BAL_EN) || (awaddr_q == `ADCD_OFF_POLARITY) ||
                  (awaddr_q == `ADCD_OFF_CAL_COEF);
  assign sum_clr = do_wr && (awaddr_q == `ADCD_OFF_ALERT) && wstrb_q[2] &&
                   !wdata_q[`ADCD_ALERT_SUM_BIT];
  assign start_req = do_wr && (awaddr_q == `ADCD_OFF_SCAN_CTRL) && wstrb_q[0] &&
                     wdata_q[`ADCD_SCAN_START_BIT] && !busy_q && !start_q;

  // byte-lane mask of the pending write, so each field keeps its unstrobed lanes
  wire [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ADCD_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      sel_a_q <= 4'h0;
      sel_b_q <= 4'h0;
      cal_en_q <= 1'b0;
      eos_en_q <= 1'b0;
      scan_cfg_q <= 3'h0;
      top_a_q <= 4'h0;
      top_b_q <= 4'h0;
      short_thr_q <= 14'h0;
      low_thr_q <= 14'h0;
      high_thr_q <= 14'h0;
      bal_en_q <= {NCH{1'b0}};
      pol_q <= {NCH{1'b0}};
      cal_coef_q <= 14'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `ADCD_RESP_OKAY : `ADCD_RESP_SLVERR;
        if (awaddr_q == `ADCD_OFF_DIAG_CFG) begin
          {eos_en_q, cal_en_q, sel_b_q, sel_a_q} <=
            ({eos_en_q, cal_en_q, sel_b_q, sel_a_q} & ~bmask[9:0]) | (wdata_q[9:0] & bmask[9:0]);
        end else if (awaddr_q == `ADCD_OFF_SCAN_CTRL && !busy_q) begin
          {top_b_q, top_a_q} <= ({top_b_q, top_a_q} & ~bmask[11:4]) | (wdata_q[11:4] & bmask[11:4]);
          if (wstrb_q[0]) begin
            scan_cfg_q <= wdata_q[2:0];
          end
        end else if (awaddr_q == `ADCD_OFF_SHORT_THR) begin
          short_thr_q <= (short_thr_q & ~bmask[13:0]) | (wdata_q[13:0] & bmask[13:0]);
        end else if (awaddr_q == `ADCD_OFF_LOW_THR) begin
          low_thr_q <= (low_thr_q & ~bmask[13:0]) | (wdata_q[13:0] & bmask[13:0]);
        end else if (awaddr_q == `ADCD_OFF_HIGH_THR) begin
          high_thr_q <= (high_thr_q & ~bmask[13:0]) | (wdata_q[13:0] & bmask[13:0]);
        end else if (awaddr_q == `ADCD_OFF_BAL_EN) begin
          bal_en_q <= (bal_en_q & ~bmask[NCH-1:0]) | (wdata_q[NCH-1:0] & bmask[NCH-1:0]);
        end else if (awaddr_q == `ADCD_OFF_POLARITY) begin
          pol_q <= (pol_q & ~bmask[NCH-1:0]) | (wdata_q[NCH-1:0] & bmask[NCH-1:0]);
        end else if (awaddr_q == `ADCD_OFF_CAL_COEF) begin
          cal_coef_q <= (cal_coef_q & ~bmask[13:0]) | (wdata_q[13:0] & bmask[13:0]);
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always @* begin
    rd_d = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] == `ADCD_OFF_DIAG_CFG >> 2) begin
      rd_d = {22'h0, eos_en_q, cal_en_q, sel_b_q, sel_a_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_SCAN_CTRL >> 2) begin
      rd_d = {20'h0, top_b_q, top_a_q, 1'b0, scan_cfg_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_RESULT_A >> 2) begin
      rd_d = {16'h0, res_a_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_RESULT_B >> 2) begin
      rd_d = {16'h0, res_b_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_SHORT_THR >> 2) begin
      rd_d = {18'h0, short_thr_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_LOW_THR >> 2) begin
      rd_d = {18'h0, low_thr_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_HIGH_THR >> 2) begin
      rd_d = {18'h0, high_thr_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_ALERT >> 2) begin
      rd_d = {15'h0, sum_q, {(16-NCH){1'b0}}, alert_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_BAL_EN >> 2) begin
      rd_d = {{(32-NCH){1'b0}}, bal_en_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_POLARITY >> 2) begin
      rd_d = {{(32-NCH){1'b0}}, pol_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_STATUS >> 2) begin
      rd_d = {30'h0, busy_q, done_flag_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_EOS_RES >> 2) begin
      rd_d = {2'h0, fs_q, 2'h0, zs_q};
    end else if (s_axi_araddr[7:2] == `ADCD_OFF_CAL_COEF >> 2) begin
      rd_d = {18'h0, cal_coef_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `ADCD_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_d;
      rresp_q <= rd_ok ? `ADCD_RESP_OKAY : `ADCD_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // per-channel masks and measurement enables
  wire swmode = mode_q[2];
  wire [NCH-1:0] top_mask;
  wire [NCH-1:0] meas_en;
  wire [NCH-1:0] wire_pat = (mode_q == `ADCD_SCAN_WIRE_ODD) ? `ADCD_ODD_PATTERN : `ADCD_EVEN_PATTERN;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      localparam [4:0] POS = g;
      assign top_mask[g] = (top_a_q == top_b_q) && (POS >= {1'b0, top_a_q});
      assign meas_en[g] = !swmode ? 1'b1 :
                          (mode_q == `ADCD_SCAN_SW_SHORT) ? !pol_q[g] :
                          (mode_q == `ADCD_SCAN_SW_OPEN) ? (bal_en_q[g] && !pol_q[g]) :
                          (wire_pat[g] && !pol_q[g] && !top_mask[g]);
    end
  endgenerate

  // ==========================================================
  // item decode: what the converter is set up for
  reg [3:0] code;
  reg item_en;
  reg [2:0] src_d;
  reg bip_d, nochop_d, therm_d;
  reg [9:0] dac_d;

  always @* begin
    code = 4'h0;
    item_en = 1'b0;
    src_d = `ADCD_SRC_CELL;
    bip_d = swmode && (mode_q != `ADCD_SCAN_SW_SHORT);
    nochop_d = 1'b0;
    therm_d = 1'b0;
    dac_d = 10'h0;
    if (idx_q < IT_A) begin
      item_en = meas_en[idx_q[3:0]];
    end else begin
      if (idx_q == IT_A) begin
        code = swmode ? 4'h0 : sel_a_q;
      end else if (idx_q == IT_B) begin
        code = swmode ? 4'h0 : sel_b_q;
      end else if (idx_q == IT_ZS) begin
        code = eos_en_q ? `ADCD_SEL_ZERO : 4'h0;
      end else if (idx_q == IT_FS) begin
        code = eos_en_q ? `ADCD_SEL_FULL : 4'h0;
      end
      item_en = 1'b1;
      case (code)
        `ADCD_SEL_THERM: begin
          src_d = `ADCD_SRC_GND_THERM;
          bip_d = 1'b1;
          therm_d = 1'b1;
        end
        `ADCD_SEL_AMP_OFS: begin
          src_d = `ADCD_SRC_AMP_SHORT;
          bip_d = 1'b1;
          nochop_d = 1'b1;
        end
        `ADCD_SEL_ZERO: begin
          src_d = `ADCD_SRC_NEG_RAIL;
          bip_d = 1'b1;
        end
        `ADCD_SEL_FULL: begin
          src_d = `ADCD_SRC_POS_RAIL;
          bip_d = 1'b1;
        end
        `ADCD_SEL_DAC_Q1: begin
          src_d = `ADCD_SRC_DAC;
          dac_d = `ADCD_DAC_Q1;
        end
        `ADCD_SEL_DAC_Q3: begin
          src_d = `ADCD_SRC_DAC;
          dac_d = `ADCD_DAC_Q3;
        end
        default: item_en = 1'b0;
      endcase
    end
  end

  wire [13:0] cal_val = (cal_en_q && code == `ADCD_SEL_THERM) ? conv_data + cal_coef_q : conv_data;
  wire fault = (mode_q == `ADCD_SCAN_SW_SHORT) ? (conv_data < short_thr_q) :
               ((conv_data < low_thr_q) || (conv_data > high_thr_q));
  wire [NCH-1:0] final_alert = pend_q & ~top_mask;

  // ==========================================================
  // scan sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      busy_q <= 1'b0;
      st_q <= ST_IDLE;
      idx_q <= 5'h0;
      mode_q <= 3'h0;
      pend_q <= {NCH{1'b0}};
      alert_q <= {NCH{1'b0}};
      sum_q <= 1'b0;
      done_flag_q <= 1'b0;
      res_a_q <= 16'h0;
      res_b_q <= 16'h0;
      zs_q <= 14'h0;
      fs_q <= 14'h0;
      cstart_q <= 1'b0;
      csrc_q <= `ADCD_SRC_CELL;
      cch_q <= 4'h0;
      cbip_q <= 1'b0;
      cnochop_q <= 1'b0;
      ctherm_q <= 1'b0;
      cdac_q <= 10'h0;
      cupd_q <= 1'b0;
      alternate_mux_path_q <= 1'b0;
      bal_drv_q <= {NCH{1'b0}};
    end else begin
      start_q <= start_req;
      cstart_q <= 1'b0;
      cupd_q <= 1'b0;
      bal_drv_q <= !busy_q ? bal_en_q :
                   (mode_q == `ADCD_SCAN_SW_SHORT) ? {NCH{1'b0}} :
                   (swmode && mode_q != `ADCD_SCAN_SW_OPEN) ? (wire_pat & ~pol_q & ~top_mask) : bal_en_q;
      alternate_mux_path_q <= busy_q && swmode;
      if (sum_clr) begin
        sum_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (start_q) begin
            busy_q <= 1'b1;
            mode_q <= scan_cfg_q;
            idx_q <= 5'h0;
            pend_q <= {NCH{1'b0}};
            done_flag_q <= 1'b0;
            st_q <= ST_NEXT;
            if (scan_cfg_q[2]) begin
              alert_q <= {NCH{1'b0}};
            end
          end
        end
        ST_NEXT: begin
          if (idx_q == IT_END) begin
            busy_q <= 1'b0;
            done_flag_q <= 1'b1;
            st_q <= ST_IDLE;
            if (swmode) begin
              alert_q <= final_alert;
              sum_q <= |final_alert;
            end
          end else if (item_en) begin
            cstart_q <= 1'b1;
            csrc_q <= src_d;
            cch_q <= idx_q[3:0];
            cbip_q <= bip_d;
            cnochop_q <= nochop_d;
            ctherm_q <= therm_d;
            cdac_q <= dac_d;
            st_q <= ST_WAIT;
          end else begin
            idx_q <= idx_q + 5'h1;
          end
        end
        ST_WAIT: begin
          if (conv_done) begin
            idx_q <= idx_q + 5'h1;
            st_q <= ST_NEXT;
            if (idx_q < IT_A) begin
              if (swmode) begin
                pend_q[idx_q[3:0]] <= fault;
              end
              // cell alerts only in normal scans
              cupd_q <= !swmode;
            end else if (idx_q == IT_A) begin
              res_a_q <= {cal_val, 2'b00};
            end else if (idx_q == IT_B) begin
              res_b_q <= {cal_val, 2'b00};
            end else if (idx_q == IT_ZS) begin
              zs_q <= conv_data;
            end else begin
              fs_q <= conv_data;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign conv_start = cstart_q;
  assign conv_src = csrc_q;
  assign conv_channel = cch_q;
  assign conv_bipolar = cbip_q;
  assign conv_no_chop = cnochop_q;
  assign conv_therm_ref = ctherm_q;
  assign dac_code = cdac_q;
  assign alternate_mux_path = alternate_mux_path_q;
  assign balance_switch_drive = bal_drv_q;
  assign cell_alert_update = cupd_q;

endmodule // adcd_top

`default_nettype wire

// file: pkg/adcd_regs.vh
// register map, field positions and selection codes of the diagnostic block
// assumes a byte-addressed 8-bit AXI4-Lite window with one 32-bit word per register
`ifndef ADCD_REGS_VH
`define ADCD_REGS_VH

// ==========================================================
// register byte offsets
`define ADCD_OFF_DIAG_CFG 8'h00
`define ADCD_OFF_SCAN_CTRL 8'h04
`define ADCD_OFF_RESULT_A 8'h08
`define ADCD_OFF_RESULT_B 8'h0c
`define ADCD_OFF_SHORT_THR 8'h10
`define ADCD_OFF_LOW_THR 8'h14
`define ADCD_OFF_HIGH_THR 8'h18
`define ADCD_OFF_ALERT 8'h1c
`define ADCD_OFF_BAL_EN 8'h20
`define ADCD_OFF_POLARITY 8'h24
`define ADCD_OFF_STATUS 8'h28
`define ADCD_OFF_EOS_RES 8'h2c
`define ADCD_OFF_CAL_COEF 8'h30

// ==========================================================
// field positions
`define ADCD_CFG_CAL_BIT 8
`define ADCD_CFG_EOS_BIT 9
`define ADCD_SCAN_START_BIT 3
`define ADCD_ALERT_SUM_BIT 16

// ==========================================================
// diagnostic selection codes
`define ADCD_SEL_THERM 4'h9
`define ADCD_SEL_AMP_OFS 4'hc
`define ADCD_SEL_ZERO 4'ha
`define ADCD_SEL_FULL 4'hb
`define ADCD_SEL_DAC_Q1 4'h8
`define ADCD_SEL_DAC_Q3 4'h7

// ==========================================================
// scan configuration codes
`define ADCD_SCAN_SW_SHORT 3'h4
`define ADCD_SCAN_SW_OPEN 3'h5
`define ADCD_SCAN_WIRE_ODD 3'h6
`define ADCD_SCAN_WIRE_EVEN 3'h7

// ==========================================================
// converter source codes and fixed values
`define ADCD_SRC_CELL 3'h0
`define ADCD_SRC_GND_THERM 3'h1
`define ADCD_SRC_AMP_SHORT 3'h2
`define ADCD_SRC_NEG_RAIL 3'h3
`define ADCD_SRC_POS_RAIL 3'h4
`define ADCD_SRC_DAC 3'h5
`define ADCD_DAC_Q1 10'h100
`define ADCD_DAC_Q3 10'h2ff
`define ADCD_ODD_PATTERN 14'h1555
`define ADCD_EVEN_PATTERN 14'h2aaa
`define ADCD_RESP_OKAY 2'h0
`define ADCD_RESP_SLVERR 2'h2

`endif

// file: tb/adcd_properties.sv
// checker for the diagnostic block, bound to its top module
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "adcd_regs.vh"
module adcd_properties #(
  parameter NCH = 14
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire conv_start,
  input wire [2:0] conv_src,
  input wire conv_bipolar,
  input wire conv_no_chop,
  input wire conv_therm_ref,
  input wire [9:0] dac_code,
  input wire alternate_mux_path,
  input wire [NCH-1:0] balance_switch_drive,
  input wire cell_alert_update
);
  // ==========
  // scan mode and read address seen on the bus
  logic [2:0] mode_q;
  logic [7:0] ar_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 3'h0;
      ar_q <= 8'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
          s_axi_awaddr == `ADCD_OFF_SCAN_CTRL && s_axi_wdata[`ADCD_SCAN_START_BIT])
        mode_q <= s_axi_wdata[2:0];
      if (s_axi_arvalid && s_axi_arready)
        ar_q <= s_axi_araddr;
    end
  end

  // ==========
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_therm_path_bipolar: assert property (conv_start && conv_src == `ADCD_SRC_GND_THERM |->
    conv_bipolar && conv_therm_ref) else $error("thermistor check not bipolar");
  a_amp_no_chop: assert property (conv_start && conv_src == `ADCD_SRC_AMP_SHORT |->
    conv_bipolar && conv_no_chop) else $error("amplifier offset check chopped");
  a_rail_bipolar: assert property (conv_start && (conv_src == `ADCD_SRC_NEG_RAIL ||
    conv_src == `ADCD_SRC_POS_RAIL) |-> conv_bipolar) else $error("rail check not bipolar");
  a_dac_code_load: assert property (conv_start && conv_src == `ADCD_SRC_DAC |->
    dac_code == `ADCD_DAC_Q1 || dac_code == `ADCD_DAC_Q3) else $error("bad dac code");
  a_short_switches_off: assert property (conv_start && mode_q == 3'h4 && alternate_mux_path |->
    balance_switch_drive == '0) else $error("switches on in short scan");
  a_switch_mux_on: assert property (conv_start && mode_q[2] |-> alternate_mux_path)
    else $error("alternate path off in switch scan");
  a_cell_alerts_held: assert property (alternate_mux_path && $past(alternate_mux_path) |->
    !cell_alert_update) else $error("cell alerts updated in switch scan");
  a_result_low_zero: assert property (s_axi_rvalid && (ar_q == `ADCD_OFF_RESULT_A ||
    ar_q == `ADCD_OFF_RESULT_B) |-> s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:16] == 16'h0)
    else $error("result word badly placed");
  c_dac: cover property (conv_start && conv_src == `ADCD_SRC_DAC);
  c_wire_even: cover property (mode_q == 3'h7 && alternate_mux_path);
  c_cell_update: cover property (cell_alert_update);
endmodule // adcd_properties

bind adcd_top adcd_properties #(.NCH(NCH)) u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .conv_start, .conv_src, .conv_bipolar, .conv_no_chop,
  .conv_therm_ref, .dac_code, .alternate_mux_path, .balance_switch_drive, .cell_alert_update);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the diagnostic block
// drives the register bus and stands in for the converter
`timescale 1ns/1ns
`default_nettype none
`include "adcd_regs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic conv_done = 1'b0;
  logic [13:0] conv_data = 14'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] conv_src;
  wire [3:0] conv_channel;
  wire [9:0] dac_code;
  logic [13:0] ch [14];
  logic [1:0] pend = 2'h0;
  logic [13:0] resp = 14'h0;
  logic [1:0] br;
  logic [1:0] rr;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  adcd_top #(.NCH(14)) uut (.*, .conv_bipolar(), .conv_no_chop(), .conv_therm_ref(),
    .alternate_mux_path(), .balance_switch_drive(), .cell_alert_update());

  always #25 aclk = ~aclk;

  // ==========
  // converter stand-in: answers each request three cycles later
  always @(posedge aclk) begin
    conv_done <= pend == 2'h1;
    conv_data <= pend == 2'h1 ? resp : ~conv_data;
    if (pend != 2'h0) pend <= pend - 2'h1;
    if (conv_start) begin
      pend <= 2'h3;
      case (conv_src)
        `ADCD_SRC_CELL: resp <= ch[conv_channel];
        `ADCD_SRC_GND_THERM: resp <= 14'h2000;
        `ADCD_SRC_AMP_SHORT: resp <= 14'h2100;
        `ADCD_SRC_POS_RAIL: resp <= 14'h3ffc;
        `ADCD_SRC_DAC: resp <= {dac_code, 4'h0};
        default: resp <= 14'h0;
      endcase
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim;
    end
  end

  // ==========
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic scan(input logic [2:0] m, input logic [3:0] ta, input logic [3:0] tc);
    logic [31:0] d;
    begin
      wr(`ADCD_OFF_SCAN_CTRL, {20'h0, tc, ta, 1'b1, m});
      if (m[2]) begin
        rd(`ADCD_OFF_ALERT, d);
        `CHK("alert clear", 14'h0, d[13:0])
      end
      do rd(`ADCD_OFF_STATUS, d); while (d[1] || !d[0]);
    end
  endtask

  function automatic logic [13:0] swexp(input logic [2:0] m, input logic [3:0] ta, input logic [3:0] tc,
    input logic [13:0] en, input logic [13:0] pol);
    logic [13:0] r;
    begin
      r = 14'h0;
      for (int g = 0; g < 14; g++)
        if (!pol[g] && !(ta == tc && g >= ta) && (m == 3'h4 || (m == 3'h5 ? en[g] : g[0] == m[0])))
          r[g] = m == 3'h4 ? ch[g] < 14'h1000 : (ch[g] < 14'h0800 || ch[g] > 14'h3000);
      swexp = r;
    end
  endfunction

  // ==========
  // scenarios
  task automatic t_diag;
    logic [31:0] d;
    begin
      wr(`ADCD_OFF_DIAG_CFG, 32'h0000_00c9);
      scan(3'h0, 4'h0, 4'h0);
      rd(`ADCD_OFF_RESULT_A, d);
      `CHK("therm", 32'h0000_8000, d)
      `CHK("therm range", 1'b1, d[15:2] >= 14'h1fb0 && d[15:2] <= 14'h204f)
      rd(`ADCD_OFF_RESULT_B, d);
      `CHK("amp", 32'h0000_8400, d)
      `CHK("amp range", 1'b1, d[15:2] >= 14'h1d59 && d[15:2] <= 14'h22a9)
      wr(`ADCD_OFF_CAL_COEF, 32'h0000_0003);
      wr(`ADCD_OFF_DIAG_CFG, 32'h0000_0109);
      scan(3'h0, 4'h0, 4'h0);
      rd(`ADCD_OFF_RESULT_A, d);
      `CHK("therm cal", 32'h0000_800c, d)
      `CHK("therm cal range", 1'b1, d[15:2] >= 14'h1ff8 && d[15:2] <= 14'h2003)
      wr(`ADCD_OFF_DIAG_CFG, 32'h0000_02ba);
      scan(3'h0, 4'h0, 4'h0);
      rd(`ADCD_OFF_RESULT_A, d);
      `CHK("zero", 32'h0000_0000, d)
      rd(`ADCD_OFF_RESULT_B, d);
      `CHK("full", 32'h0000_fff0, d)
      rd(`ADCD_OFF_EOS_RES, d);
      `CHK("eos", 32'h3ffc_0000, d)
      wr(`ADCD_OFF_DIAG_CFG, 32'h0000_0078);
      scan(3'h0, 4'h0, 4'h0);
      rd(`ADCD_OFF_RESULT_A, d);
      `CHK("dac q1", 32'h0000_4000, d)
      `CHK("dac q1 range", 1'b1, d[15:2] >= 14'h0fa0 && d[15:2] <= 14'h1060)
      rd(`ADCD_OFF_RESULT_B, d);
      `CHK("dac q3", 32'h0000_bfc0, d)
      `CHK("dac q3 range", 1'b1, d[15:2] >= 14'h2f70 && d[15:2] <= 14'h3080)
    end
  endtask

  task automatic t_sw;
    logic [31:0] d;
    logic [13:0] e;
    logic [2:0] m;
    logic [3:0] ta;
    logic [3:0] tc;
    begin
      wr(`ADCD_OFF_SHORT_THR, 32'h0000_1000);
      wr(`ADCD_OFF_LOW_THR, 32'h0000_0800);
      wr(`ADCD_OFF_HIGH_THR, 32'h0000_3000);
      wr(`ADCD_OFF_BAL_EN, 32'h0000_3c3f);
      wr(`ADCD_OFF_POLARITY, 32'h0000_0102);
      for (int k = 0; k < 8; k++) begin
        m = {1'b1, k[1:0]};
        ta = k[2] ? 4'hd : 4'ha;
        tc = k[2] ? 4'hc : 4'ha;
        scan(m, ta, tc);
        e = swexp(m, ta, tc, 14'h3c3f, 14'h0102);
        rd(`ADCD_OFF_ALERT, d);
        `CHK("alerts", {15'h0, |e, 2'h0, e}, d)
      end
      scan(3'h0, 4'h0, 4'h0);
      rd(`ADCD_OFF_ALERT, d);
      `CHK("alerts kept", {15'h0, |e, 2'h0, e}, d)
      wr(`ADCD_OFF_ALERT, 32'h0000_0000);
      rd(`ADCD_OFF_ALERT, d);
      `CHK("summary clear", {18'h0, e}, d)
    end
  endtask

  task automatic t_bus;
    logic [31:0] d;
    begin
      rd(8'h3c, d);
      `CHK("rresp", `ADCD_RESP_SLVERR, rr)
      `CHK("rdata", 32'h0, d)
      wr(8'h3c, 32'h0000_0001);
      `CHK("bresp", `ADCD_RESP_SLVERR, br)
    end
  endtask

  task automatic end_sim;
    begin
      if (fails == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  initial begin
    for (int i = 0; i < 14; i++) ch[i] = {i[3:0], 10'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_diag;
    t_sw;
    t_bus;
    end_sim;
  end
endmodule // tb
`default_nettype wire
